/* File: sim/can_bus_model.sv */
// bus receive side model: drives falling edges at a chosen spacing
// assumes the caller enters send_edges 1 ns after a rising clk edge
`timescale 1ns/1ps
module can_bus_model (
	// clock
	input  wire logic clk,
	// receive line, recessive high when idle
	output logic      can_rx
);
	initial can_rx = 1'b1;

	// dominant pulse kept short so the spacing is set by falling edges only
	task automatic send_edges(input int count, input int gap);
		for (int i = 0; i < count; i++) begin
			can_rx = 1'b0;
			repeat (20) @(posedge clk);
			#1 can_rx = 1'b1;
			repeat (gap - 20) @(posedge clk);
			#1;
		end
	endtask
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the recovery configuration block
// assumes design files and the bus model are compiled before this file
`timescale 1ns/1ps
`include "cdr_config_regs.svh"
module testbench;
	logic       clk, resetn, clk_en, restart, reg_wr, reg_rd, can_rx, active;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, cal_high_in, cal_low_in, rec_bt, rd;
	logic [7:0] btl, lim_hi, lim_lo;
	logic [2:0] fshift;
	int         num_errors = 0;
	int         checks = 0;
	int         cycles = 0;

	wake_frame_cdr_config i_wake_frame_cdr_config (.clk(clk), .resetn(resetn), .clk_en(clk_en),
		.restart(restart), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cal_high_in(cal_high_in),
		.cal_low_in(cal_low_in), .bit_time_length_value(btl), .upper_bit_time_limit(lim_hi),
		.lower_bit_time_limit(lim_lo), .can_rx(can_rx), .recovered_bit_time(rec_bt),
		.filter_shift(fshift), .recovery_active(active));
	can_bus_model i_can_bus_model (.clk(clk), .can_rx(can_rx));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			num_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic tick;
		@(posedge clk);
		#1;
	endtask

	// strobe drops for one idle cycle so back-to-back calls never reassign it in one step
	task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		tick();
		reg_wr = 1'b0;
		tick();
	endtask

	task automatic reg_read(input logic [6:0] a);
		reg_addr = a;
		reg_rd = 1'b1;
		tick();
		rd = reg_rdata;
		reg_rd = 1'b0;
		tick();
	endtask

	// enable with given settings, send edges, then disable again so tracking idles
	task automatic run_edges(input logic [7:0] c1, input logic [7:0] c2, input int gap, input int n);
		reg_write(`ADDR_RECOVERY_CTRL2, c2);
		reg_write(`ADDR_RECOVERY_CTRL1, c1);
		tick();
		tick();
		i_can_bus_model.send_edges(n, gap);
		repeat (20) tick();
		reg_write(`ADDR_RECOVERY_CTRL1, 8'h00);
	endtask

	task automatic test_reset;
		reg_read(`ADDR_RECOVERY_CTRL1);
		check(rd, 8'h04, "ctrl1 reset");
		reg_read(`ADDR_RECOVERY_CTRL2);
		check(rd, 8'h00, "ctrl2 reset");
		check({5'h0, fshift}, 8'h04, "shift reset");
		check({7'h0, active}, 8'h00, "idle after reset");
		check(rec_bt, 8'h00, "bit time reset");
	endtask

	task automatic test_regs;
		reg_write(`ADDR_RECOVERY_CTRL1, 8'hff);
		reg_read(`ADDR_RECOVERY_CTRL1);
		check(rd, 8'h0d, "ctrl1 reserved");
		tick();
		check({7'h0, active}, 8'h01, "enabled");
		reg_write(`ADDR_RECOVERY_CTRL1, 8'h00);
		reg_read(`ADDR_RECOVERY_CTRL1);
		check(rd, 8'h00, "ctrl1 cleared");
		tick();
		check({7'h0, active}, 8'h00, "disabled");
		reg_write(`ADDR_RECOVERY_CTRL2, 8'hff);
		reg_read(`ADDR_RECOVERY_CTRL2);
		check(rd, 8'h03, "ctrl2 reserved");
		clk_en = 1'b0;
		reg_write(`ADDR_RECOVERY_CTRL2, 8'h01);
		clk_en = 1'b1;
		reg_read(`ADDR_RECOVERY_CTRL2);
		check(rd, 8'h03, "frozen by clock enable");
		reg_write(`ADDR_OSC_CAL_HIGH, 8'h55);
		reg_read(`ADDR_OSC_CAL_HIGH);
		check(rd, 8'hc3, "cal high");
		reg_write(`ADDR_OSC_CAL_LOW, 8'h11);
		reg_read(`ADDR_OSC_CAL_LOW);
		check(rd, 8'h5a, "cal low");
		reg_read(7'h40);
		check(rd, 8'h00, "unmapped");
	endtask

	task automatic test_restart;
		reg_write(`ADDR_RECOVERY_CTRL1, 8'h09);
		reg_write(`ADDR_RECOVERY_CTRL2, 8'h02);
		restart = 1'b1;
		tick();
		restart = 1'b0;
		reg_read(`ADDR_RECOVERY_CTRL1);
		check(rd, 8'h09, "ctrl1 kept");
		reg_read(`ADDR_RECOVERY_CTRL2);
		check(rd, 8'h02, "ctrl2 kept");
		resetn = 1'b0;
		tick();
		resetn = 1'b1;
		test_reset();
	endtask

	task automatic test_filter;
		for (int f = 0; f < 3; f++) begin
			run_edges({4'h0, f[1:0], 2'b01}, 8'h00, 320, 3);
			check({5'h0, fshift}, 8'(3 + f), "fixed constant");
			check(rec_bt, 8'ha0, "steady bit time");
		end
	endtask

	task automatic test_adapt;
		int gaps [3] = '{320, 800, 1440};
		int exps [3] = '{5, 4, 3};
		for (int i = 0; i < 3; i++) begin
			run_edges(8'h0d, 8'h00, gaps[i], 3);
			check({5'h0, fshift}, 8'(exps[i]), "adaptive constant");
		end
	endtask

	// gap scaled with the divider keeps 320 ticks, inside the counter range
	task automatic test_clock_select;
		for (int c = 0; c < 4; c++) begin
			run_edges(8'h0d, {6'h0, c[1:0]}, 320 << c, 3);
			check({5'h0, fshift}, 8'h05, "clock select");
		end
	endtask

	task automatic test_clamp_disable;
		run_edges(8'h01, 8'h00, 540, 8);
		check(rec_bt, 8'ha8, "upper clamp");
		run_edges(8'h01, 8'h00, 420, 8);
		check(rec_bt, 8'h98, "lower clamp");
		i_can_bus_model.send_edges(4, 480);
		repeat (20) tick();
		check(rec_bt, 8'h98, "no tracking when off");
		check({7'h0, active}, 8'h00, "idle when off");
	endtask

	initial begin
		resetn = 1'b0;
		clk_en = 1'b1;
		restart = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 7'h00;
		reg_wdata = 8'h00;
		cal_high_in = 8'hc3;
		cal_low_in = 8'h5a;
		btl = 8'ha0;
		lim_hi = 8'ha8;
		lim_lo = 8'h98;
		repeat (8) @(posedge clk);
		#1 resetn = 1'b1;
		test_reset();
		test_regs();
		test_restart();
		test_filter();
		test_adapt();
		test_clock_select();
		test_clamp_disable();
		print_verdict();
	end
endmodule

/* File: verilog/cdr_config_pkg.sv */
// types shared by the recovery configuration block
// assumes cdr_config_regs.svh is included by the design file
package cdr_config_pkg;

	typedef enum logic [1:0] {
		rec_idle,
		rec_wait_edge,
		rec_measure
	} rec_state_type;

	typedef struct packed {
		logic       enable;
		logic [1:0] filt;
		logic [1:0] clk_sel;
	} settings_type;

	typedef struct packed {
		settings_type  cfg;
		logic [7:0]    cal_high;
		logic [7:0]    cal_low;
		logic [7:0]    rdata;
		rec_state_type state;
		logic          active;
		logic [2:0]    div_cnt;
		logic          tick;
		logic [10:0]   spacing;
		logic [12:0]   estimate;
		logic [7:0]    bit_time;
		logic [2:0]    tc_shift;
		logic          updated;
		logic          rx_meta;
		logic          rx_sync;
		logic          rx_prev;
	} cdr_state_type;

endpackage

/* File: verilog/cdr_config_regs.svh */
// register offsets, field positions, reset values and tick counts of the recovery block
// assumes the serial port front end presents 7-bit register addresses
`ifndef CDR_CONFIG_REGS_SVH
`define CDR_CONFIG_REGS_SVH

`define ADDR_OSC_CAL_HIGH      7'h3a
`define ADDR_OSC_CAL_LOW       7'h3b
`define ADDR_RECOVERY_CTRL1    7'h3c
`define ADDR_RECOVERY_CTRL2    7'h3d

`define CTRL1_ENABLE_BIT       0
`define CTRL1_FILT_LSB         2
`define CTRL1_FILT_MSB         3
`define CTRL2_CLKSEL_LSB       0
`define CTRL2_CLKSEL_MSB       1

`define CTRL1_RESET            8'h04
`define CTRL2_RESET            8'h00
`define CAL_RESET              8'h00

// filter codes and time constants as right shifts (8, 16, 32)
`define FILT_TC8               2'h0
`define FILT_TC16              2'h1
`define FILT_TC32              2'h2
`define FILT_ADAPT             2'h3
`define SHIFT_TC8              3'h3
`define SHIFT_TC16             3'h4
`define SHIFT_TC32             3'h5

// clk counts as the 80 MHz reference step; selections divide by 1, 2, 4, 8
`define CLKSEL_DIV_MAX         3'h7
`define FRAC_BITS              5
`define SPACING_MAX            11'h7ff
`define MIN_BITS               4'h2
`define MAX_BITS               4'ha
`define ADAPT_FAST_MAX         4'h3
`define ADAPT_MID_MAX          4'h8

`endif

/* File: verilog/wake_frame_cdr_config.sv */
// recovery control and calibration registers plus the bit-time tracking loop
// assumes a serial port front end giving single-cycle read and write strobes,
// and bit-time/limit settings held by neighbouring registers on the same clock
`timescale 1ns/1ps
`include "cdr_config_regs.svh"

// Operation
// - The high calibration byte is read-only and follows the oscillator calibration result.
// - The low calibration byte is read-only, completes the result and clears on reset.
// - Filter code 00 gives time constant 8, 01 gives 16 and 10 gives 32.
// - The filter code resets to 01 so the first control register reads 0x04.
// - Filter code 11 adapts: 32 for 2-3 bit edge spacing, 16 for 4-8, 8 for 9-10.
// - Reserved bits of both control registers read as zero.
// - The clock select field picks 80, 40, 20 or 10 MHz for the recovery logic.
// - The recovered bit time is clamped between the upper and lower limits.
module wake_frame_cdr_config
	import cdr_config_pkg::*;
(
	// clock, reset, enable
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       clk_en,
	input  wire logic       restart,
	// register port
	input  wire logic [6:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// calibration result and timing settings
	input  wire logic [7:0] cal_high_in,
	input  wire logic [7:0] cal_low_in,
	input  wire logic [7:0] bit_time_length_value,
	input  wire logic [7:0] upper_bit_time_limit,
	input  wire logic [7:0] lower_bit_time_limit,
	// bus receive pin and recovery status
	input  wire logic       can_rx,
	output logic      [7:0] recovered_bit_time,
	output logic      [2:0] filter_shift,
	output logic            recovery_active
);

	cdr_state_type s;
	cdr_state_type next_s;

	// nearest whole bit count for a spacing, 0 when out of range
	function automatic logic [3:0] nearest_bits(input logic [15:0] span, input logic [12:0] est);
		logic [3:0]  k;
		logic [17:0] bound;
		k = 4'h0;
		for (int i = `MAX_BITS; i >= `MIN_BITS; i--) begin
			bound = 18'(i) * 18'(est) + 18'(est >> 1);
			if ({2'h0, span} < bound) begin
				k = 4'(i);
			end
		end
		if ({2'h0, span} < 18'(`MIN_BITS - 4'h1) * 18'(est) + 18'(est >> 1)) begin
			k = 4'h0;
		end
		return k;
	endfunction

	logic [15:0] span;
	logic [3:0]  bits;
	logic [15:0] per_bit;
	logic [15:0] diff;
	logic [12:0] filtered;
	logic [12:0] hi_fix;
	logic [12:0] lo_fix;
	logic [2:0]  use_shift;
	logic [2:0]  div_max;
	logic        fall;

	always_comb begin
		next_s = s;
		span = {s.spacing, 5'h00};
		bits = nearest_bits(span, s.estimate);
		per_bit = (bits == 4'h0) ? 16'h0000 : span / 16'(bits);
		hi_fix = {upper_bit_time_limit, 5'h00};
		lo_fix = {lower_bit_time_limit, 5'h00};
		fall = s.rx_prev && !s.rx_sync;
		case (s.cfg.filt)
			`FILT_TC8: use_shift = `SHIFT_TC8;
			`FILT_TC16: use_shift = `SHIFT_TC16;
			`FILT_TC32: use_shift = `SHIFT_TC32;
			default: begin
				if (bits <= `ADAPT_FAST_MAX) begin
					use_shift = `SHIFT_TC32;
				end else if (bits <= `ADAPT_MID_MAX) begin
					use_shift = `SHIFT_TC16;
				end else begin
					use_shift = `SHIFT_TC8;
				end
			end
		endcase
		diff = 16'(per_bit) - 16'(s.estimate);
		filtered = 13'(16'(s.estimate) + 16'($signed(diff) >>> use_shift));
		case (s.cfg.clk_sel)
			2'h0: div_max = 3'h0;
			2'h1: div_max = 3'h1;
			2'h2: div_max = 3'h3;
			default: div_max = `CLKSEL_DIV_MAX;
		endcase
		next_s.rx_meta = can_rx;
		next_s.rx_sync = s.rx_meta;
		next_s.rx_prev = s.rx_sync;
		next_s.cal_high = cal_high_in;
		next_s.cal_low = cal_low_in;
		next_s.updated = 1'b0;
		if (s.div_cnt >= div_max) begin
			next_s.div_cnt = 3'h0;
			next_s.tick = 1'b1;
		end else begin
			next_s.div_cnt = s.div_cnt + 3'h1;
			next_s.tick = 1'b0;
		end
		// writes only touch the control fields; calibration bytes ignore them
		if (reg_wr) begin
			case (reg_addr)
				`ADDR_RECOVERY_CTRL1: begin
					next_s.cfg.enable = reg_wdata[`CTRL1_ENABLE_BIT];
					next_s.cfg.filt = reg_wdata[`CTRL1_FILT_MSB:`CTRL1_FILT_LSB];
				end
				`ADDR_RECOVERY_CTRL2: next_s.cfg.clk_sel = reg_wdata[`CTRL2_CLKSEL_MSB:`CTRL2_CLKSEL_LSB];
				default: next_s.cfg = s.cfg;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				`ADDR_OSC_CAL_HIGH: next_s.rdata = s.cal_high;
				`ADDR_OSC_CAL_LOW: next_s.rdata = s.cal_low;
				`ADDR_RECOVERY_CTRL1: next_s.rdata = {4'h0, s.cfg.filt, 1'b0, s.cfg.enable};
				`ADDR_RECOVERY_CTRL2: next_s.rdata = {6'h00, s.cfg.clk_sel};
				default: next_s.rdata = 8'h00;
			endcase
		end
		case (s.state)
			rec_idle: begin
				next_s.estimate = {bit_time_length_value, 5'h00};
				next_s.spacing = 11'h000;
				if (s.cfg.enable) begin
					next_s.state = rec_wait_edge;
				end
			end
			rec_wait_edge: begin
				if (fall) begin
					// the edge cycle's tick opens the new interval, else one tick is lost
					next_s.spacing = {10'h000, s.tick};
					next_s.state = rec_measure;
				end
			end
			rec_measure: begin
				if (fall) begin
					next_s.spacing = {10'h000, s.tick};
					if (bits != 4'h0) begin
						next_s.tc_shift = use_shift;
						next_s.updated = 1'b1;
						if (filtered > hi_fix) begin
							next_s.estimate = hi_fix;
						end else if (filtered < lo_fix) begin
							next_s.estimate = lo_fix;
						end else begin
							next_s.estimate = filtered;
						end
						next_s.bit_time = next_s.estimate[12:`FRAC_BITS];
					end
				end else if (s.tick && s.spacing != `SPACING_MAX) begin
					next_s.spacing = s.spacing + 11'h001;
				end
			end
			default: next_s.state = rec_idle;
		endcase
		if (!s.cfg.enable) begin
			next_s.state = rec_idle;
		end
		if (restart) begin
			next_s.state = rec_idle;
			next_s.cfg = s.cfg;
		end
		// status kept in its own flop so the pin never shows decode glitches
		next_s.active = (next_s.state != rec_idle);
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s <= '{cfg: '{enable: 1'b0, filt: `FILT_TC16, clk_sel: 2'h0},
				cal_high: `CAL_RESET, cal_low: `CAL_RESET, rdata: 8'h00,
				state: rec_idle, active: 1'b0, div_cnt: 3'h0, tick: 1'b0, spacing: 11'h000,
				estimate: 13'h0000, bit_time: 8'h00, tc_shift: `SHIFT_TC16,
				updated: 1'b0, rx_meta: 1'b1, rx_sync: 1'b1, rx_prev: 1'b1};
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;
	assign recovered_bit_time = s.bit_time;
	assign filter_shift = s.tc_shift;
	assign recovery_active = s.active;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_ctrl1_read;
		clk_en && reg_rd && reg_addr == `ADDR_RECOVERY_CTRL1;
	endsequence

	sequence s_update;
		clk_en && s.state == rec_measure && fall && bits != 4'h0;
	endsequence

	property p_cal_high;
		clk_en |=> s.cal_high == $past(cal_high_in);
	endproperty
	a_cal_high: assert property (p_cal_high) else $error("high calibration byte wrong");

	property p_cal_low_reset;
		@(posedge clk) disable iff (1'b0) !resetn |=> s.cal_low == 8'h00;
	endproperty
	a_cal_low_reset: assert property (p_cal_low_reset) else $error("low byte not cleared");

	property p_filter_fixed;
		s_update ##0 s.cfg.filt != `FILT_ADAPT
			|=> filter_shift == 3'($past(s.cfg.filt)) + `SHIFT_TC8;
	endproperty
	a_filter_fixed: assert property (p_filter_fixed) else $error("fixed constant wrong");

	property p_reset_value;
		@(posedge clk) disable iff (1'b0) !resetn ##1 (resetn && !reg_wr)[*1] ##0 s_ctrl1_read
			|=> reg_rdata == `CTRL1_RESET;
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("control reset value wrong");

	property p_adapt;
		(clk_en && s.cfg.filt == `FILT_ADAPT && s.state == rec_measure && fall
			&& bits >= `MIN_BITS && bits <= `ADAPT_FAST_MAX) |=> filter_shift == `SHIFT_TC32;
	endproperty
	a_adapt: assert property (p_adapt) else $error("adaptive constant not 32");

	property p_adapt_slow;
		s_update ##0 s.cfg.filt == `FILT_ADAPT && bits > `ADAPT_MID_MAX |=> filter_shift == `SHIFT_TC8;
	endproperty
	a_adapt_slow: assert property (p_adapt_slow) else $error("adaptive constant not 8");

	property p_enable;
		clk_en && !s.cfg.enable |=> !recovery_active;
	endproperty
	a_enable: assert property (p_enable) else $error("tracking while disabled");

	property p_reserved;
		s_ctrl1_read |=> reg_rdata[7:4] == 4'h0 && reg_rdata[1] == 1'b0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

	property p_clk_slow;
		clk_en && s.tick && s.cfg.clk_sel == 2'h3 && !reg_wr |=> !s.tick;
	endproperty
	a_clk_slow: assert property (p_clk_slow) else $error("10 MHz step ticks too often");

	property p_restart;
		clk_en && restart |=> s.cfg == $past(s.cfg) && !recovery_active;
	endproperty
	a_restart: assert property (p_restart) else $error("restart lost settings");

	property p_clamp;
		clk_en && s.updated && $past(lower_bit_time_limit) <= $past(upper_bit_time_limit)
			|-> s.bit_time <= $past(upper_bit_time_limit)
			&& s.bit_time >= $past(lower_bit_time_limit);
	endproperty
	a_clamp: assert property (p_clamp) else $error("bit time outside limits");

endmodule
